// ### verilog/pcs_core_addr.sv
// Purpose: Program counter, holding latch, return stack and indirect data addressing
// Assumes: Execute stage gives one operation per cycle; instruction fetch uses pc
// Notes: Indirect port address has no storage; requests are remapped to memory
// Functional notes
// RULE_01 - Keep a 13-bit program counter; its low byte is readable and writable.
// RULE_02 - Upper five counter bits load only from the holding latch; code also sets them on step carry, jump, return and interrupt.
// RULE_03 - Any reset clears the whole program counter to zero.
// RULE_04 - Writing the low byte copies latch bits 4:0 into the upper bits.
// RULE_05 - Call and jump take the two top counter bits from latch bits 4:3.
// RULE_06 - Software adding to the low byte must bump the latch on rollover.
// RULE_07 - Eight-entry 13-bit return stack with a hidden pointer.
// RULE_08 - Push the counter on calls and on interrupt vectoring.
// RULE_09 - Pop into the counter on return, literal return and interrupt return.
// RULE_10 - Push and pop leave the holding latch unchanged.
// RULE_11 - Stack is circular; the ninth push overwrites the first entry.
// RULE_12 - No stack overflow or underflow flag exists.
// RULE_13 - Indirect port has no storage; accesses go to the pointer's location.
// RULE_14 - Indirect read that lands on the indirect port returns zero.
// RULE_15 - Indirect write that lands on the indirect port stores nothing.
// RULE_16 - Indirect address is bank select bit over the 8-bit pointer.
// RULE_17 - Call and jump take the low eleven counter bits from the operand.
// RULE_18 - Excess pops wrap the hidden pointer and return stored data silently.
`include "pcs_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module pcs_core_addr (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire pcs_pkg::pcs_pc_req_s pc_req,
    input wire logic lath_we,
    input wire logic [7:0] lath_wdata,
    input wire logic ptr_we,
    input wire logic [7:0] ptr_wdata,
    input wire logic indirect_bank_select,
    input wire pcs_pkg::pcs_mem_req_s core_mem_req,
    input wire logic [7:0] mem_rdata,
    output pcs_pkg::pcs_pc_t pc,
    output logic [7:0] pc_low_byte,
    output logic [7:0] pc_high_holding_latch,
    output logic [7:0] file_select_pointer,
    output pcs_pkg::pcs_mem_req_s mem_req,
    output logic [7:0] core_rdata
);

    pcs_pkg::pcs_pc_t pc_r;
    pcs_pkg::pcs_pc_t pc_nxt;
    logic [`PCS_LATH_W-1:0] lath_r;
    logic [`PCS_LATH_W-1:0] lath_nxt;
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic push;
    logic pop;
    pcs_pkg::pcs_pc_t stack_top;
    pcs_pkg::pcs_pc_t ret_addr;
    logic is_indirect;
    logic [`PCS_DADDR_W-1:0] ind_addr;
    logic ind_self;

    // Bank-relative test; the indirect port appears in every bank
    function automatic logic hits_port(input logic [`PCS_DADDR_W-1:0] a);
        hits_port = (a[6:0] == `PCS_INDIRECT_PORT_ADDR);
    endfunction : hits_port

    // Return address is the instruction after the one executing
    assign ret_addr = pc_r + 13'h0001;

    // Pushes and pops never touch the latch (see RULE_10)
    assign push = (pc_req.op == pcs_pkg::PCS_OP_CALL) || (pc_req.op == pcs_pkg::PCS_OP_IRQ); // see RULE_08
    assign pop = (pc_req.op == pcs_pkg::PCS_OP_RETURN); // see RULE_09

    pcs_return_stack #(
        .DEPTH(`PCS_STACK_DEPTH),
        .SP_W(`PCS_SP_W)
    ) u_stack (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .push(push),
        .pop(pop),
        .push_data(ret_addr),
        .top_data(stack_top)
    ); // see RULE_07

    always_comb begin
        pc_nxt = pc_r;
        case (pc_req.op)
            pcs_pkg::PCS_OP_STEP: begin
                pc_nxt = pc_r + 13'h0001;
            end
            pcs_pkg::PCS_OP_LOW_WRITE: begin
                // Whole counter changes at once; no carry out of low byte
                pc_nxt = {lath_r, pc_req.low_data}; // see RULE_04 see RULE_02
            end
            pcs_pkg::PCS_OP_JUMP, pcs_pkg::PCS_OP_CALL: begin
                pc_nxt = {lath_r[4:3], pc_req.jump_addr}; // see RULE_05 see RULE_17
            end
            pcs_pkg::PCS_OP_IRQ: begin
                pc_nxt = pc_req.irq_vector; // see RULE_08
            end
            pcs_pkg::PCS_OP_RETURN: begin
                pc_nxt = stack_top; // see RULE_09 see RULE_18
            end
            pcs_pkg::PCS_OP_HOLD: begin
                pc_nxt = pc_r;
            end
            default: begin
                pc_nxt = pc_r;
            end
        endcase
    end

    always_comb begin
        lath_nxt = lath_r;
        ptr_nxt = ptr_r;
        if (lath_we) begin
            lath_nxt = lath_wdata[`PCS_LATH_W-1:0];
        end
        if (ptr_we) begin
            ptr_nxt = ptr_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_r <= `PCS_PC_RESET; // see RULE_03
            lath_r <= '0;
            ptr_r <= '0;
        end else begin
            pc_r <= pc_nxt; // see RULE_01
            lath_r <= lath_nxt;
            ptr_r <= ptr_nxt;
        end
    end

    assign pc = pc_r;
    assign pc_low_byte = pc_r[7:0]; // see RULE_01
    assign pc_high_holding_latch = {3'h0, lath_r};
    assign file_select_pointer = ptr_r;

    // Indirect addressing remap
    assign is_indirect = core_mem_req.valid && hits_port(core_mem_req.addr); // see RULE_13
    assign ind_addr = {indirect_bank_select, ptr_r}; // see RULE_16
    assign ind_self = hits_port(ind_addr);

    always_comb begin
        mem_req = core_mem_req;
        core_rdata = mem_rdata;
        if (is_indirect) begin
            mem_req.addr = ind_addr; // see RULE_13
            if (ind_self) begin
                // Self reference: no storage behind it (see RULE_14) (see RULE_15)
                mem_req.valid = 1'b0;
                mem_req.write = 1'b0;
                core_rdata = `PCS_READ_ZERO;
            end
        end
    end

    low_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_04
        pc_req.op == pcs_pkg::PCS_OP_LOW_WRITE |=> pc_r == {$past(lath_r), $past(pc_req.low_data)})
        else $error("Low byte write did not load latch bits");

    jump_top_bits_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_05
        (pc_req.op == pcs_pkg::PCS_OP_JUMP || pc_req.op == pcs_pkg::PCS_OP_CALL)
        |=> pc_r[12:11] == $past(lath_r[4:3]))
        else $error("Jump top bits not from latch");

    jump_low_bits_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_17
        pc_req.op == pcs_pkg::PCS_OP_JUMP |=> pc_r[10:0] == $past(pc_req.jump_addr))
        else $error("Jump low bits not from operand");

    call_return_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_09
        (pc_req.op == pcs_pkg::PCS_OP_CALL) ##1 (pc_req.op == pcs_pkg::PCS_OP_RETURN)
        |=> pc_r == $past(pc_r, 2) + 13'h0001)
        else $error("Return did not restore call site");

    latch_kept_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_10
        (push || pop) && !lath_we |=> $stable(lath_r))
        else $error("Stack action changed latch");

    ind_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_16
        is_indirect && !ind_self |-> mem_req.valid && mem_req.addr == {indirect_bank_select, ptr_r})
        else $error("Indirect address not formed from pointer");

    self_read_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_14
        is_indirect && ind_self && !core_mem_req.write |-> core_rdata == 8'h00 && !mem_req.valid)
        else $error("Self indirect read not zero");

    self_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_15
        is_indirect && ind_self |-> !mem_req.write)
        else $error("Self indirect write reached memory");

    upper_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_02
        pc_req.op == pcs_pkg::PCS_OP_HOLD |=> $stable(pc_r))
        else $error("Counter moved while held");

    step_incr_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_01
        pc_req.op == pcs_pkg::PCS_OP_STEP |=> pc_r == $past(pc_r) + 13'h0001)
        else $error("Counter did not step by one");

    irq_vector_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_08
        pc_req.op == pcs_pkg::PCS_OP_IRQ |=> pc_r == $past(pc_req.irq_vector))
        else $error("Interrupt did not load vector");

    push_top_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_08
        push |=> stack_top == $past(ret_addr))
        else $error("Pushed address not on stack top");

    latch_load_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_02
        lath_we |=> lath_r == $past(lath_wdata[`PCS_LATH_W-1:0]))
        else $error("Latch did not take written bits");

    ptr_load_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_16
        ptr_we |=> ptr_r == $past(ptr_wdata))
        else $error("Pointer did not take written value");

    ind_read_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_13
        is_indirect && !ind_self |-> core_rdata == mem_rdata)
        else $error("Indirect read data not passed back");

    direct_pass_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_13
        core_mem_req.valid && !is_indirect |-> mem_req == core_mem_req)
        else $error("Direct access was altered");

endmodule : pcs_core_addr

`default_nettype wire

// ### verilog/pcs_defs.svh
// Purpose: Constants for the program counter, return stack and indirect addressing block
// Assumes: One core clock, instruction-level strobes from the execute stage
// Notes: Included by the package and by the design modules
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

`define PCS_PC_W 13
`define PCS_PC_RESET 13'h0000
`define PCS_STACK_DEPTH 8
`define PCS_SP_W 3
`define PCS_LATH_W 5
`define PCS_JUMP_OPERAND_W 11
`define PCS_PTR_W 8
`define PCS_DADDR_W 9
// Address of the indirect data port within each bank
`define PCS_INDIRECT_PORT_ADDR 7'h00
`define PCS_READ_ZERO 8'h00

`endif

// ### verilog/pcs_pkg.sv
// Purpose: Types for the program counter, return stack and indirect addressing block
// Assumes: Constants come from pcs_defs.svh
// Notes: Nothing is imported; users write pcs_pkg::name
`include "pcs_defs.svh"

package pcs_pkg;

    typedef logic [`PCS_PC_W-1:0] pcs_pc_t;

    // Program counter operation requested by the execute stage
    typedef enum logic [6:0] {
        PCS_OP_STEP = 7'h01,
        PCS_OP_LOW_WRITE = 7'h02,
        PCS_OP_JUMP = 7'h04,
        PCS_OP_CALL = 7'h08,
        PCS_OP_IRQ = 7'h10,
        PCS_OP_RETURN = 7'h20,
        PCS_OP_HOLD = 7'h40
    } pcs_op_e;

    typedef struct packed {
        pcs_op_e op;
        logic [7:0] low_data;
        logic [`PCS_JUMP_OPERAND_W-1:0] jump_addr;
        logic [`PCS_PC_W-1:0] irq_vector;
    } pcs_pc_req_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [`PCS_DADDR_W-1:0] addr;
        logic [7:0] wdata;
    } pcs_mem_req_s;

endpackage : pcs_pkg

// ### verilog/pcs_return_stack.sv
// Purpose: Eight-entry circular return-address stack
// Assumes: Push and pop never arrive in the same cycle
// Notes: Pointer is hidden; no overflow or underflow indication exists
`include "pcs_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module pcs_return_stack #(
    parameter int DEPTH = `PCS_STACK_DEPTH,
    parameter int SP_W = `PCS_SP_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic push,
    input wire logic pop,
    input wire pcs_pkg::pcs_pc_t push_data,
    output pcs_pkg::pcs_pc_t top_data
);

    pcs_pkg::pcs_pc_t mem_r [DEPTH];
    pcs_pkg::pcs_pc_t mem_nxt [DEPTH];
    logic [SP_W-1:0] sp_r;
    logic [SP_W-1:0] sp_nxt;
    logic [SP_W-1:0] top_idx;

    // Entry last pushed sits one below the write pointer
    assign top_idx = sp_r - 1'b1;
    assign top_data = mem_r[top_idx];

    always_comb begin
        mem_nxt = mem_r;
        sp_nxt = sp_r;
        if (push) begin
            // Wraps freely, ninth push overwrites the first one (see RULE_11)
            mem_nxt[sp_r] = push_data;
            sp_nxt = sp_r + 1'b1;
        end else if (pop) begin
            // Excess pops just wrap with no error (see RULE_18) (see RULE_12)
            sp_nxt = sp_r - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_r <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            sp_r <= sp_nxt;
            mem_r <= mem_nxt;
        end
    end

    ninth_push_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_11
        push |=> (sp_r == $past(sp_r) + 3'h1) && (mem_r[$past(sp_r)] == $past(push_data)))
        else $error("Push did not store at pointer and advance");

    pop_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_18
        (pop && !push) |=> sp_r == $past(sp_r) - 3'h1)
        else $error("Pop did not step pointer back");

endmodule : pcs_return_stack

`default_nettype wire

// ### test/pcs_mem_model.sv
// Purpose: Data memory standing behind the indirect addressing logic
// Assumes: Combinational read, write on the rising edge
// Notes: Unselected read data is the inverse of the last value, so stale data never matches
`timescale 1ns/10ps
`default_nettype none

module pcs_mem_model (
    input wire logic core_clk,
    input wire pcs_pkg::pcs_mem_req_s mem_req,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:511];
    logic [7:0] last_r = 8'h00;

    always @(posedge core_clk) begin
        if (mem_req.valid && mem_req.write) begin
            mem[mem_req.addr] <= mem_req.wdata;
        end
        last_r <= ~mem_rdata;
    end

    assign mem_rdata = mem_req.valid ? mem[mem_req.addr] : last_r;
endmodule : pcs_mem_model
`default_nettype wire

// ### test/tb.sv
// Purpose: Self-checking bench for the program counter, stack and indirect addressing
// Assumes: Inputs change on the falling edge; one op per cycle
// Notes: Expected values are worked out by hand from the latch and operand values
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    pcs_pkg::pcs_pc_req_s pc_req = '0;
    logic lath_we = 1'b0;
    logic [7:0] lath_wdata = 8'h00;
    logic ptr_we = 1'b0;
    logic [7:0] ptr_wdata = 8'h00;
    logic indirect_bank_select = 1'b0;
    pcs_pkg::pcs_mem_req_s core_mem_req = '0;
    pcs_pkg::pcs_mem_req_s mem_req;
    pcs_pkg::pcs_pc_t pc;
    logic [7:0] low, lath, ptr, core_rdata, mem_rdata;
    int err_total = 0;
    int num_checks = 0;

    always #25 core_clk = ~core_clk;

    pcs_core_addr i_pcs_core_addr (.core_clk(core_clk), .rst_n(rst_n), .pc_req(pc_req),
        .lath_we(lath_we), .lath_wdata(lath_wdata), .ptr_we(ptr_we), .ptr_wdata(ptr_wdata),
        .indirect_bank_select(indirect_bank_select), .core_mem_req(core_mem_req),
        .mem_rdata(mem_rdata), .pc(pc), .pc_low_byte(low), .pc_high_holding_latch(lath),
        .file_select_pointer(ptr), .mem_req(mem_req), .core_rdata(core_rdata));

    pcs_mem_model i_pcs_mem_model (.core_clk(core_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

    task automatic chk(input string n, input logic [12:0] e, input logic [12:0] s);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // Op applied at a falling edge stays in force until the next call
    task automatic issue(input pcs_pkg::pcs_op_e o, input logic [10:0] a);
        pc_req.op = o;
        pc_req.low_data = a[7:0];
        pc_req.jump_addr = a;
        @(negedge core_clk);
    endtask : issue

    task automatic mem_acc(input logic w, input logic [8:0] a, input logic [7:0] d);
        core_mem_req = '{1'b1, w, a, d};
        #1;
    endtask : mem_acc

    task automatic t_reset();
        repeat (2) @(negedge core_clk);
        chk("pc", 13'h0000, pc);
        chk("latch", 13'h0000, lath);
        rst_n = 1'b1;
    endtask : t_reset

    // Second reset in mid-run must clear the counter at once
    task automatic t_rerst();
        rst_n = 1'b0;
        #1;
        chk("pc", 13'h0000, pc);
        chk("latch", 13'h0000, lath);
        @(negedge core_clk);
        rst_n = 1'b1;
    endtask : t_rerst

    task automatic t_low();
        lath_we = 1'b1;
        lath_wdata = 8'hfa;
        @(negedge core_clk);
        lath_we = 1'b0;
        chk("latch", 13'h001a, lath);
        issue(pcs_pkg::PCS_OP_LOW_WRITE, 11'h034);
        chk("pc", 13'h1a34, pc);
        chk("low", 13'h0034, low);
        // Table crossed a page edge: software bumps the latch before adding again
        lath_we = 1'b1;
        lath_wdata = 8'h1b;
        issue(pcs_pkg::PCS_OP_HOLD, 11'h000);
        lath_we = 1'b0;
        chk("pc", 13'h1a34, pc);
        issue(pcs_pkg::PCS_OP_LOW_WRITE, 11'h002);
        chk("pc", 13'h1b02, pc);
        issue(pcs_pkg::PCS_OP_HOLD, 11'h000);
    endtask : t_low

    task automatic t_jump();
        issue(pcs_pkg::PCS_OP_JUMP, 11'h123);
        chk("pc", 13'h1923, pc);
        issue(pcs_pkg::PCS_OP_HOLD, 11'h000);
    endtask : t_jump

    task automatic t_call();
        issue(pcs_pkg::PCS_OP_CALL, 11'h010);
        chk("pc", 13'h1810, pc);
        issue(pcs_pkg::PCS_OP_IRQ, 11'h000);
        chk("pc", 13'h0004, pc);
        issue(pcs_pkg::PCS_OP_STEP, 11'h000);
        issue(pcs_pkg::PCS_OP_RETURN, 11'h000);
        chk("pc", 13'h1811, pc);
        issue(pcs_pkg::PCS_OP_RETURN, 11'h000);
        chk("pc", 13'h1924, pc);
        chk("latch", 13'h001b, lath);
        issue(pcs_pkg::PCS_OP_HOLD, 11'h000);
    endtask : t_call

    // Nine calls wrap the eight entries; the extra pop wraps too
    task automatic t_wrap();
        for (int i = 0; i < 9; i++) begin
            issue(pcs_pkg::PCS_OP_CALL, i[10:0]);
        end
        for (int k = 0; k < 8; k++) begin
            issue(pcs_pkg::PCS_OP_RETURN, 11'h000);
            chk("pop", 13'h1808 - k[12:0], pc);
        end
        issue(pcs_pkg::PCS_OP_RETURN, 11'h000);
        chk("pop", 13'h1808, pc);
        issue(pcs_pkg::PCS_OP_HOLD, 11'h000);
    endtask : t_wrap

    task automatic t_ind();
        ptr_we = 1'b1;
        ptr_wdata = 8'h20;
        indirect_bank_select = 1'b1;
        @(negedge core_clk);
        ptr_we = 1'b0;
        chk("pointer", 13'h0020, ptr);
        mem_acc(1'b1, 9'h080, 8'h5a);
        chk("addr", 13'h0120, mem_req.addr);
        @(negedge core_clk);
        mem_acc(1'b0, 9'h000, 8'h00);
        chk("rdata", 13'h005a, core_rdata);
        @(negedge core_clk);
        // Request dropped so no stray location is read while the pointer moves
        core_mem_req = '0;
        ptr_we = 1'b1;
        ptr_wdata = 8'h80;
        indirect_bank_select = 1'b0;
        @(negedge core_clk);
        ptr_we = 1'b0;
        mem_acc(1'b0, 9'h000, 8'h00);
        chk("rdata", 13'h0000, core_rdata);
        mem_acc(1'b1, 9'h000, 8'h77);
        chk("valid", 13'h0000, {mem_req.valid, mem_req.write});
        @(negedge core_clk);
        mem_acc(1'b0, 9'h120, 8'h00);
        chk("direct", 13'h005a, core_rdata);
        @(negedge core_clk);
        core_mem_req = '0;
    endtask : t_ind

    task automatic print_verdict();
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        pc_req.op = pcs_pkg::PCS_OP_HOLD;
        pc_req.irq_vector = 13'h0004;
        t_reset();
        t_low();
        t_jump();
        t_call();
        t_wrap();
        t_rerst();
        t_ind();
        print_verdict();
    end

    initial begin
        #20000;
        err_total++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
